// [logic/dfc_dyn_floor.sv]
// Dynamic fan-start-temperature control register bank and adjust loop
//
// Contract
// - Bit 0 is the top bit of the remote-2 interval code.
// - Interval code sets monitoring cycles between successive fan-start adjustments.
// - Bit 1 is reserved, read-only; writes change nothing.
// - Remote-1 capture flag set: alarm copies remote-1 temperature to its operating point.
// - Remote-1 capture flag clear: alarm ignored, operating point keeps programmed value.
// - Local capture flag set: alarm copies local temperature to its operating point.
// - Local capture flag clear: alarm ignored, local operating point unchanged.
// - Remote-2 capture flag set: alarm copies remote-2 temperature to its operating point.
// - Remote-2 capture flag clear: alarm ignored, remote-2 operating point unchanged.
// - Bit 5 enables dynamic fan-start adjustment on remote 1.
// - Bit 6 enables dynamic fan-start adjustment on the local channel.
// - Bit 7 enables dynamic fan-start adjustment on remote 2.
// - Enabled channel adjusts fan-start from temperature, operating point and limits.
// - Disabled channel keeps programmed fan-start value under ordinary automatic control.
// - With lock set, writes to this register have no effect.
// - Code 000 is 4 down / 8 up cycles, doubling per code step.
// - Lock bit makes lockable registers read-only until power cycles.
// - Operating points reset to 100 degrees Celsius.
`timescale 1ns/100ps
`default_nettype none
module dfc_dyn_floor (
    input  wire logic                            clk_sys,
    input  wire logic                            rst_n,
    input  wire dfc_pkg::dfc_req_s               bus_req,
    output logic [7:0]                           bus_rdata,
    input  wire logic                            thermal_alarm_pin_n,
    input  wire logic                            monitor_tick,
    input  wire dfc_pkg::dfc_chan_s [2:0]        chan,
    input  wire logic [dfc_pkg::DFC_CODE_W-1:0]  remote1_cycle_code,
    input  wire logic [dfc_pkg::DFC_CODE_W-1:0]  local_cycle_code,
    input  wire logic [1:0]                      remote2_cycle_lsbs,
    output dfc_pkg::dfc_byte_t [2:0]             fan_start_temp,
    output logic [2:0]                           dyn_floor_active,
    output logic                                 regs_locked
);
    import dfc_pkg::*;

    dfc_byte_t                 ctrl1_q;
    logic                      lock_q;
    dfc_byte_t                 oppt_q   [DFC_NCH];
    dfc_byte_t                 floor_q  [DFC_NCH];
    dfc_state_e                st_q     [DFC_NCH];
    logic [DFC_CODE_W-1:0]     code     [DFC_NCH];
    logic [DFC_NCH-1:0]        dec_req;
    logic [DFC_NCH-1:0]        inc_req;
    logic [DFC_NCH-1:0]        dec_due;
    logic [DFC_NCH-1:0]        inc_due;
    logic [DFC_NCH-1:0]        run;
    logic                      alarm_lvl_n;
    logic                      alarm_q;
    logic                      alarm_d1_q;
    logic                      alarm_rise;
    logic                      wr_open;
    dfc_byte_t                 rdata_d;
    dfc_byte_t                 rdata_q;

    // Thermal alarm pin: active low, synchronised, edge taken
    dfc_sync #(
        .RST_VAL (1'b1)
    ) u_alarm_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin     (thermal_alarm_pin_n),
        .level   (alarm_lvl_n)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alarm_q    <= 1'b0;
            alarm_d1_q <= 1'b0;
        end else begin
            alarm_q    <= ~alarm_lvl_n;
            alarm_d1_q <= alarm_q;
        end
    end

    assign alarm_rise = alarm_q & ~alarm_d1_q;

    // Lock bit: write-once, held until reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == DFC_ADDR_CFG1 && bus_req.wdata[DFC_BIT_LOCK]) begin
            lock_q <= 1'b1;
        end
    end

    assign wr_open     = bus_req.wr & ~lock_q;
    assign regs_locked = lock_q;

    // Control register one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_q <= DFC_CTRL1_RST;
        end else if (wr_open && bus_req.addr == DFC_ADDR_CTRL1) begin
            ctrl1_q <= bus_req.wdata & DFC_CTRL1_WMSK;
        end
    end

    // Interval codes; remote 2 takes its top bit from bit 0
    assign code[0] = remote1_cycle_code;
    assign code[1] = local_cycle_code;
    assign code[2] = {ctrl1_q[DFC_BIT_R2MSB], remote2_cycle_lsbs};

    for (genvar i = 0; i < DFC_NCH; i++) begin : g_ch
        // Operating point: alarm capture wins over a software write
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                oppt_q[i] <= DFC_OPPT_RST;
            end else if (alarm_rise && ctrl1_q[DFC_BIT_CAP0 + i]) begin
                oppt_q[i] <= chan[i].temp;
            end else if (wr_open && bus_req.addr == DFC_ADDR_OPPT0 + 8'(i)) begin
                oppt_q[i] <= bus_req.wdata;
            end
        end

        // Channel mode follows its enable bit
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                st_q[i] <= DFC_ST_FOLLOW;
            end else begin
                case (st_q[i])
                    DFC_ST_FOLLOW: begin
                        if (ctrl1_q[DFC_BIT_DYN0 + i]) begin
                            st_q[i] <= DFC_ST_TRACK;
                        end
                    end
                    DFC_ST_TRACK: begin
                        if (!ctrl1_q[DFC_BIT_DYN0 + i]) begin
                            st_q[i] <= DFC_ST_FOLLOW;
                        end
                    end
                    default: begin
                        st_q[i] <= DFC_ST_FOLLOW;
                    end
                endcase
            end
        end

        assign run[i]     = (st_q[i] == DFC_ST_TRACK) & ctrl1_q[DFC_BIT_DYN0 + i];
        // Hot at or above the operating point: start fans earlier
        assign dec_req[i] = (chan[i].temp >= oppt_q[i]) && (floor_q[i] > chan[i].low);
        // Cool at or below the low limit: start fans later
        assign inc_req[i] = (chan[i].temp <= chan[i].low) && (floor_q[i] < chan[i].high);

        dfc_interval #(
            .CNT_W (DFC_CNT_W)
        ) u_interval (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .run     (run[i]),
            .tick    (monitor_tick),
            .code    (code[i]),
            .dec_req (dec_req[i]),
            .inc_req (inc_req[i]),
            .dec_due (dec_due[i]),
            .inc_due (inc_due[i])
        );

        // Fan-start temperature
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                floor_q[i] <= DFC_ZERO;
            end else if (!run[i]) begin
                floor_q[i] <= chan[i].floor_prog;
            end else if (dec_due[i]) begin
                floor_q[i] <= floor_q[i] - 8'h01;
            end else if (inc_due[i]) begin
                floor_q[i] <= floor_q[i] + 8'h01;
            end
        end

        assign fan_start_temp[i]   = floor_q[i];
        assign dyn_floor_active[i] = run[i];

        a_cap_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
            alarm_rise && ctrl1_q[DFC_BIT_CAP0 + i] |=> oppt_q[i] == $past(chan[i].temp))
            else $error("operating point did not capture temperature");
        a_cap_ignore: assert property (@(posedge clk_sys) disable iff (!rst_n)
            !ctrl1_q[DFC_BIT_CAP0 + i] && !(bus_req.wr && bus_req.addr == DFC_ADDR_OPPT0 + 8'(i))
            |=> $stable(oppt_q[i]))
            else $error("operating point changed without write or capture");
        a_follow_prog: assert property (@(posedge clk_sys) disable iff (!rst_n)
            !ctrl1_q[DFC_BIT_DYN0 + i] ##1 !ctrl1_q[DFC_BIT_DYN0 + i] |=> floor_q[i] == $past(chan[i].floor_prog))
            else $error("disabled channel did not keep programmed fan-start value");
        a_dec_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
            dec_due[i] |=> floor_q[i] == $past(floor_q[i]) - 8'h01)
            else $error("fan-start temperature did not step down");
        a_inc_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
            inc_due[i] |=> floor_q[i] == $past(floor_q[i]) + 8'h01)
            else $error("fan-start temperature did not step up");
        a_enable_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
            $rose(ctrl1_q[DFC_BIT_DYN0 + i]) |=> dyn_floor_active[i])
            else $error("dynamic control not started one cycle after enable");
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_comb begin
        rdata_d = DFC_ZERO;
        if (bus_req.addr == DFC_ADDR_CTRL1) begin
            rdata_d = ctrl1_q;
        end else if (bus_req.addr == DFC_ADDR_CFG1) begin
            rdata_d[DFC_BIT_LOCK] = lock_q;
        end else begin
            for (int k = 0; k < DFC_NCH; k++) begin
                if (bus_req.addr == DFC_ADDR_OPPT0 + 8'(k)) begin
                    rdata_d = oppt_q[k];
                end
                if (bus_req.addr == DFC_ADDR_CUR0 + 8'(k)) begin
                    rdata_d = floor_q[k];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= DFC_ZERO;
        end else if (bus_req.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= DFC_ZERO;
        end
    end

    assign bus_rdata = rdata_q;

    a_lock_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n) lock_q |=> lock_q)
        else $error("lock bit cleared without reset");
    a_ctrl_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n) lock_q |=> $stable(ctrl1_q))
        else $error("control register changed while locked");
    a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) ctrl1_q[DFC_BIT_RSVD] == 1'b0)
        else $error("reserved bit not zero");
    a_rd_ctrl: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == DFC_ADDR_CTRL1 |=> bus_rdata == $past(ctrl1_q))
        else $error("control register read data wrong");
    a_r2_msb: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_req.wr && !lock_q && bus_req.addr == DFC_ADDR_CTRL1 |=> code[2][2] == $past(bus_req.wdata[DFC_BIT_R2MSB]))
        else $error("remote-2 code top bit not taken from bit 0");

    c_capture: cover property (@(posedge clk_sys) disable iff (!rst_n) alarm_rise && ctrl1_q[DFC_BIT_CAP0]);
    c_locked_wr: cover property (@(posedge clk_sys) disable iff (!rst_n) lock_q && bus_req.wr);
    c_inc_step: cover property (@(posedge clk_sys) disable iff (!rst_n) |inc_due);
endmodule
`default_nettype wire

// [logic/dfc_pkg.sv]
// Shared constants and types of the dynamic fan-start-temperature control block
package dfc_pkg;
    localparam int        DFC_NCH        = 3;
    localparam int        DFC_CODE_W     = 3;
    localparam int        DFC_CNT_W      = 11;
    localparam int        DFC_DEC_BASE   = 4;
    localparam int        DFC_INC_BASE   = 8;
    localparam logic [7:0] DFC_ADDR_OPPT0 = 8'h33;
    localparam logic [7:0] DFC_ADDR_CTRL1 = 8'h36;
    localparam logic [7:0] DFC_ADDR_CFG1  = 8'h40;
    localparam logic [7:0] DFC_ADDR_CUR0  = 8'h90;
    localparam logic [7:0] DFC_OPPT_RST   = 8'h64;
    localparam logic [7:0] DFC_CTRL1_RST  = 8'h00;
    localparam logic [7:0] DFC_CTRL1_WMSK = 8'hFD;
    localparam logic [7:0] DFC_ZERO       = 8'h00;
    localparam int        DFC_BIT_R2MSB  = 0;
    localparam int        DFC_BIT_RSVD   = 1;
    localparam int        DFC_BIT_CAP0   = 2;
    localparam int        DFC_BIT_DYN0   = 5;
    localparam int        DFC_BIT_LOCK   = 1;

    typedef logic [7:0] dfc_byte_t;

    typedef struct packed {
        logic [7:0] addr;
        dfc_byte_t  wdata;
        logic       wr;
        logic       rd;
    } dfc_req_s;

    typedef struct packed {
        dfc_byte_t temp;
        dfc_byte_t low;
        dfc_byte_t high;
        dfc_byte_t floor_prog;
    } dfc_chan_s;

    typedef enum logic [1:0] {
        DFC_ST_FOLLOW = 2'b00,
        DFC_ST_TRACK  = 2'b01
    } dfc_state_e;
endpackage

// [logic/dfc_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module dfc_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Change taken once stages two and three agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= RST_VAL;
        end else if (s2_q == s3_q) begin
            lvl_q <= s3_q;
        end
    end

    assign level = lvl_q;
endmodule
`default_nettype wire

// [logic/dfc_interval.sv]
// Per-channel adjustment interval timer counted in monitoring cycles
`timescale 1ns/100ps
`default_nettype none
module dfc_interval #(
    parameter int CNT_W = dfc_pkg::DFC_CNT_W
) (
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    input  wire logic                           run,
    input  wire logic                           tick,
    input  wire logic [dfc_pkg::DFC_CODE_W-1:0] code,
    input  wire logic                           dec_req,
    input  wire logic                           inc_req,
    output logic                                dec_due,
    output logic                                inc_due
);
    import dfc_pkg::*;

    if (CNT_W < DFC_CNT_W) begin : g_chk
        $error("dfc_interval: CNT_W too small for the longest interval");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] dec_len;
    logic [CNT_W-1:0] inc_len;
    logic             at_max;

    // Code n gives 4 << n cycles down and 8 << n cycles up
    assign dec_len = CNT_W'(DFC_DEC_BASE) << code;
    assign inc_len = CNT_W'(DFC_INC_BASE) << code;
    assign at_max  = &cnt_q;
    assign dec_due = run & tick & dec_req & (cnt_q >= dec_len - CNT_W'(1));
    assign inc_due = run & tick & ~dec_req & inc_req & (cnt_q >= inc_len - CNT_W'(1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!run || dec_due || inc_due) begin
            cnt_q <= '0;
        end else if (tick && !at_max) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    a_dec_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n) dec_due |=> !dec_due [*3])
        else $error("decrease steps closer than four cycles");
    a_inc_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n) inc_due |=> !inc_due [*7])
        else $error("increase steps closer than eight cycles");
    c_dec_step: cover property (@(posedge clk_sys) disable iff (!rst_n) dec_due);
endmodule
`default_nettype wire

// [tb/test_dfc_dyn_floor.sv]
// Self-checking testbench for the dynamic fan-start-temperature control block
`timescale 1ns/100ps
`default_nettype none
module test_dfc_dyn_floor;
    import dfc_pkg::*;
    logic            clk_sys = 1'b0;
    logic            rst_n = 1'b0;
    dfc_req_s        req = '0;
    logic [7:0]      rdata;
    logic            alarm_n = 1'b1;
    logic            tick = 1'b0;
    dfc_chan_s [2:0] chan = '0;
    logic [2:0]      code1 = 3'h0;
    logic [2:0]      code_l = 3'h0;
    logic [1:0]      lsbs2 = 2'h0;
    dfc_byte_t [2:0] fst;
    logic [2:0]      active;
    logic            locked;
    int              fails = 0;
    int              cmp_count = 0;
    logic [7:0]      m_ctrl = 8'h00;
    logic [7:0]      m_op [3] = '{8'h64, 8'h64, 8'h64};
    logic            m_lock = 1'b0;
    int              n;
    int              base;

    always #20 clk_sys = ~clk_sys;

    dfc_dyn_floor dfc_dyn_floor_inst (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .bus_req            (req),
        .bus_rdata          (rdata),
        .thermal_alarm_pin_n(alarm_n),
        .monitor_tick       (tick),
        .chan               (chan),
        .remote1_cycle_code (code1),
        .local_cycle_code   (code_l),
        .remote2_cycle_lsbs (lsbs2),
        .fan_start_temp     (fst),
        .dyn_floor_active   (active),
        .regs_locked        (locked)
    );

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: %s got %0h expected %0h", $time, what, g, e);
        end
    endtask

    // Write cycle, then the model follows the register map
    task automatic mwr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
        #1;
        if (!m_lock) begin
            if (a == DFC_ADDR_CTRL1)
                m_ctrl = d & 8'hFD;
            if (a >= DFC_ADDR_OPPT0 && a <= DFC_ADDR_OPPT0 + 8'h02)
                m_op[a - DFC_ADDR_OPPT0] = d;
            if (a == DFC_ADDR_CFG1 && d[1])
                m_lock = 1'b1;
        end
    endtask

    // Read cycle; data stands in the cycle after the strobe
    task automatic creg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, e}, "register read");
    endtask

    // Enable one channel and count ticks until its fan-start value steps
    task automatic measure(input int ch, input logic [7:0] ctl, input logic inc, output int cnt);
        dfc_byte_t start;
        start = chan[ch].floor_prog;
        mwr(DFC_ADDR_CTRL1, ctl);
        cnt = 0;
        while (fst[ch] === start && cnt < 1200) begin
            @(posedge clk_sys) tick <= 1'b1;
            @(posedge clk_sys) tick <= 1'b0;
            #1;
            cnt++;
        end
        chk({15'h0, active[ch]}, 16'h1, "dynamic active");
        chk({8'h0, fst[ch]}, {8'h0, inc ? start + 8'h01 : start - 8'h01}, "step value");
        for (int j = 0; j < 3; j++)
            if (j != ch)
                chk({8'h0, fst[j]}, {8'h0, chan[j].floor_prog}, "idle channel");
        mwr(DFC_ADDR_CTRL1, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({8'h0, fst[ch]}, {8'h0, start}, "disabled follows");
        chk({15'h0, active[ch]}, 16'h0, "disabled flag");
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        void'($urandom(35368));
        for (int i = 0; i < 3; i++)
            chan[i] = '{temp: 8'h50, low: 8'h10, high: 8'h70, floor_prog: 8'h30};
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        creg(DFC_ADDR_CTRL1, 8'h00);
        for (int i = 0; i < 3; i++)
            creg(DFC_ADDR_OPPT0 + 8'(i), 8'h64);
        chk({15'h0, locked}, 16'h0, "lock at reset");
        chk({8'h0, fst[1]}, 16'h0030, "follow at reset");
        $display("test reset_values done");
        repeat (4) begin
            mwr(DFC_ADDR_CTRL1, 8'($urandom));
            creg(DFC_ADDR_CTRL1, m_ctrl);
            mwr(8'h50, 8'($urandom));
            creg(8'h50, 8'h00);
        end
        mwr(DFC_ADDR_CTRL1, 8'h00);
        $display("test register_access done");
        for (int m = 0; m < 8; m++) begin
            @(posedge clk_sys);
            for (int i = 0; i < 3; i++)
                chan[i].temp <= 8'($urandom);
            mwr(DFC_ADDR_CTRL1, 8'(m << 2));
            for (int i = 0; i < 3; i++)
                mwr(DFC_ADDR_OPPT0 + 8'(i), 8'($urandom));
            alarm_n <= 1'b0;
            repeat (8) @(posedge clk_sys);
            alarm_n <= 1'b1;
            repeat (4) @(posedge clk_sys);
            for (int i = 0; i < 3; i++) begin
                if (m[i])
                    m_op[i] = chan[i].temp;
                creg(DFC_ADDR_OPPT0 + 8'(i), m_op[i]);
            end
        end
        mwr(DFC_ADDR_CTRL1, 8'h00);
        $display("test alarm_capture done");
        for (int ch = 0; ch < 3; ch++) begin
            @(posedge clk_sys);
            for (int i = 0; i < 3; i++)
                chan[i].temp <= 8'h50;
            code1 <= 3'h0;
            code_l <= 3'h0;
            lsbs2 <= 2'h0;
            mwr(DFC_ADDR_OPPT0 + 8'(ch), 8'h40);
            measure(ch, 8'h20 << ch, 1'b0, n);
            base = n - 4;
            for (int k = 1; k < 8; k++) begin
                @(posedge clk_sys);
                chan[ch].temp <= 8'h50;
                if (ch == 0)
                    code1 <= 3'(k);
                else if (ch == 1)
                    code_l <= 3'(k);
                else
                    lsbs2 <= 2'(k);
                measure(ch, (8'h20 << ch) | ((ch == 2) ? 8'(k >> 2) : 8'h00), 1'b0, n);
                chk(16'(n), 16'(base + (4 << k)), "decrease interval");
                @(posedge clk_sys);
                chan[ch].temp <= 8'h08;
                measure(ch, (8'h20 << ch) | ((ch == 2) ? 8'(k >> 2) : 8'h00), 1'b1, n);
                chk(16'(n), 16'(base + (8 << k)), "increase interval");
            end
        end
        $display("test dynamic_loop done");
        mwr(DFC_ADDR_CFG1, 8'h02);
        chk({15'h0, locked}, 16'h1, "lock set");
        mwr(DFC_ADDR_CTRL1, 8'hE4);
        creg(DFC_ADDR_CTRL1, m_ctrl);
        mwr(DFC_ADDR_OPPT0, 8'h11);
        creg(DFC_ADDR_OPPT0, m_op[0]);
        creg(DFC_ADDR_CFG1, 8'h02);
        creg(DFC_ADDR_CUR0, 8'h30);
        $display("test lock done");
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({8'h0, fst[0]}, 16'h0000, "fan-start in reset");
        chk({8'h0, rdata}, 16'h0000, "read data in reset");
        @(posedge clk_sys);
        rst_n <= 1'b1;
        m_lock = 1'b0;
        m_ctrl = 8'h00;
        for (int i = 0; i < 3; i++)
            m_op[i] = 8'h64;
        creg(DFC_ADDR_CTRL1, 8'h00);
        chk({15'h0, locked}, 16'h0, "lock after power cycle");
        creg(DFC_ADDR_OPPT0 + 8'h02, 8'h64);
        mwr(DFC_ADDR_CTRL1, 8'hE7);
        creg(DFC_ADDR_CTRL1, m_ctrl);
        mwr(DFC_ADDR_CTRL1, 8'h00);
        $display("test power_cycle done");
        report_and_stop();
    end
endmodule
`default_nettype wire
